// File: inc/retimer_params.svh
// register offsets, field positions, reset values and timing counts of the channel override block
`ifndef RETIMER_PARAMS_SVH
`define RETIMER_PARAMS_SVH

// ==================================================
// register offsets
`define OFS_APPLIED_BOOST 8'h03
`define OFS_CAP_FIRST 8'h08
`define OFS_OVERRIDE_EN 8'h09
`define OFS_CAP_SECOND 8'h0b
`define OFS_EQ_LIMIT 8'h13
`define OFS_DETECT_OVR 8'h14
`define OFS_OUTPUT_SEL 8'h1e
`define OFS_RATE_SUBRATE 8'h2f
`define OFS_ADAPT_MODE 8'h31
`define OFS_SEARCH_CFG 8'h36
`define OFS_LOW_RATE_BOOST 8'h3a
`define OFS_RESEARCH_DIS 8'h3f
`define OFS_SECONDARY_BOOST 8'h40

// ==================================================
// field positions
`define BIT_CAP_OVR 7
`define BIT_MUX_OVR 5
`define BIT_QCLK_EN_A 4
`define BIT_QCLK_EN_B 0
`define BIT_EQ_LIMIT 2
`define BIT_RESEARCH_DIS 7
`define SEL_HI 7
`define SEL_LO 5
`define ADAPT_HI 6
`define ADAPT_LO 5
`define SEARCH_HI 5
`define SEARCH_LO 4
`define REFMODE_HI 2
`define REFMODE_LO 0

// ==================================================
// reset values
`define RST_OUTPUT_SEL 8'he0
`define RST_SEARCH_CFG 8'h31
`define RST_ADAPT_MODE 8'h20
`define RST_ZERO 8'h00

// ==================================================
// output select codes
`define MUX_MUTE 3'h7
`define MUX_INVALID 3'h6
`define MUX_OSC10 3'h5
`define MUX_PRBS 3'h4
`define MUX_QCLK 3'h3
`define MUX_ICLK 3'h2
`define MUX_RETIMED 3'h1
`define MUX_RAW 3'h0

// divider codes: 0..3 give ratios 1, 2, 4, 8
`define DIV_BY1 3'h0
`define DIV_BY4 3'h2
`define DIV_BY8 3'h3

// ==================================================
// timing
`define CLK_MHZ 100
`define REF_MHZ 25
`define REF_DIV (`CLK_MHZ / `REF_MHZ)
`define OSC_MHZ 10
`define OSC_HALF (`CLK_MHZ / (2 * `OSC_MHZ))
`define LOCK_TRY_US 2
`define LOCK_TRY_CYC (`LOCK_TRY_US * `CLK_MHZ)
`define RESEARCH_NS 500
`define RESEARCH_CYC ((`RESEARCH_NS * `CLK_MHZ) / 1000)
`define SEARCH_SPAN 8

`endif

// File: inc/retimer_pkg.sv
// types of the channel override block
`include "retimer_params.svh"
package retimer_pkg;
	typedef logic [2:0] mux_sel_t;
	typedef logic [15:0] word_t;
	typedef enum logic [2:0] {st_off, st_search, st_try, st_adapt, st_locked, st_research} chan_state_t;
	typedef struct packed {
		logic [7:0] boost;
		logic [7:0] cap1;
		logic [7:0] ovr;
		logic [7:0] cap2;
		logic [7:0] eqlim;
		logic [7:0] detovr;
		logic [7:0] osel;
		logic [7:0] rate;
		logic [7:0] adapt;
		logic [7:0] search;
		logic [7:0] lowb;
		logic [7:0] rdis;
		logic [7:0] secb;
		logic [2:0] written;
		chan_state_t st;
		logic [15:0] tmr;
		logic [1:0] refdiv;
		logic [2:0] oscdiv;
		logic osc;
		logic [4:0] cap;
		logic [2:0] div;
		logic alt;
		word_t buf0;
		word_t buf1;
		logic [1:0] cnt;
		logic in_rdy;
		logic ovalid;
		logic [7:0] rdata;
		logic rvalid;
		logic pwr;
		mux_sel_t sel;
		logic vsync;
	} chan_t;
endpackage : retimer_pkg

// File: hdl/retimer_channel_override_ctrl.sv
// channel override control: boost, coarse vco search, output mux and signal detect
//
// Summary of operation
// RL1: boost register shows and takes applied boost
// RL2: one bit puts last stage into limiting
// RL3: lock loss restarts lock and adaptation sequence
// RL4: adapt mode zero leaves boost untouched
// RL5: relock starts at highest allowed divider; code starts at divide-by-1 when search bits 2:0 are zero
// RL6: dividers four, eight use low-rate boost
// RL7: adapt zero, all boosts programmed: no change
// RL8: search field 11 runs reference-timed cap search
// RL9: rate and subrate set search range
// RL10: cap override values act only when enabled
// RL11: override alternates first/div8, second/div1
// RL12: default output muted unless locked and detected
// RL13: three-bit select decodes to seven outputs
// RL14: software enables quadrature clock before selecting it
// RL15: select applies only when unlocked, default mutes
// RL16: mux override makes select always apply; the code still mutes during re-search and with no signal
// RL17: re-search disable keeps output alive
// RL18: no signal powers channel and driver down
// RL19: detect override forces on or returns auto
// RL20: locked outputs synchronous, else free-running vco
// RL21: 10 MHz oscillator selectable under override
// RL22: invalid select code behaves as mute
`timescale 1ns/10ps
`include "retimer_params.svh"
module retimer_channel_override_ctrl (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic sig_detect,
	input wire logic lock_det,
	input wire logic freq_ok,
	input wire logic adapt_valid,
	input wire logic [7:0] adapt_boost,
	input wire logic adapt_done,
	input wire logic in_valid,
	output logic in_ready,
	input wire retimer_pkg::word_t retimed_data,
	input wire retimer_pkg::word_t raw_data,
	input wire retimer_pkg::word_t prbs_data,
	input wire retimer_pkg::word_t iclk_data,
	input wire retimer_pkg::word_t qclk_data,
	output logic out_valid,
	input wire logic out_ready,
	output retimer_pkg::word_t out_data,
	output logic [7:0] boost_out,
	output logic eq_limit_out,
	output logic [4:0] cap_dac_out,
	output logic [2:0] div_code_out,
	output logic chan_power_en,
	output retimer_pkg::mux_sel_t mux_sel,
	output logic vco_sync
);
	import retimer_pkg::*;

	chan_t s;
	chan_t n;
	logic sd_eff;
	logic ref_tick;
	logic go_try;
	logic hold_boost;
	logic push;
	logic pop;
	word_t src_word;
	mux_sel_t sel_raw;

	// ==================================================
	// helpers
	function automatic logic [2:0] max_div(input logic [7:0] rate_reg);
		max_div = {1'b0, rate_reg[5:4]};
	endfunction : max_div

	function automatic logic [4:0] search_base(input logic [7:0] rate_reg);
		search_base = {rate_reg[7:6], rate_reg[5:4], 1'b0};
	endfunction : search_base

	// ==================================================
	// next state
	always_comb begin
		n = s;
		n.rvalid = 1'b0;
		go_try = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		src_word = 16'h0000;
		sel_raw = `MUX_MUTE;
		ref_tick = (s.refdiv == 2'(`REF_DIV - 1));
		n.refdiv = s.refdiv + 2'h1;
		if (s.oscdiv == 3'(`OSC_HALF - 1)) begin
			n.oscdiv = 3'h0;
			n.osc = ~s.osc;
		end else begin
			n.oscdiv = s.oscdiv + 3'h1;
		end

		// register port
		if (reg_wr) begin
			case (reg_addr)
				`OFS_APPLIED_BOOST: begin
					n.boost = reg_wdata; // RL1
					n.written[1] = 1'b1;
				end
				`OFS_CAP_FIRST: n.cap1 = reg_wdata;
				`OFS_OVERRIDE_EN: n.ovr = reg_wdata;
				`OFS_CAP_SECOND: n.cap2 = reg_wdata;
				`OFS_EQ_LIMIT: n.eqlim = reg_wdata; // RL2
				`OFS_DETECT_OVR: n.detovr = reg_wdata;
				`OFS_OUTPUT_SEL: n.osel = reg_wdata;
				`OFS_RATE_SUBRATE: n.rate = reg_wdata;
				`OFS_ADAPT_MODE: n.adapt = reg_wdata;
				`OFS_SEARCH_CFG: n.search = reg_wdata;
				`OFS_LOW_RATE_BOOST: begin
					n.lowb = reg_wdata;
					n.written[0] = 1'b1;
				end
				`OFS_RESEARCH_DIS: n.rdis = reg_wdata;
				`OFS_SECONDARY_BOOST: begin
					n.secb = reg_wdata;
					n.written[2] = 1'b1;
				end
				default: ;
			endcase
		end
		if (reg_rd) begin
			n.rvalid = 1'b1;
			case (reg_addr)
				`OFS_APPLIED_BOOST: n.rdata = s.boost; // RL1
				`OFS_CAP_FIRST: n.rdata = s.cap1;
				`OFS_OVERRIDE_EN: n.rdata = s.ovr;
				`OFS_CAP_SECOND: n.rdata = s.cap2;
				`OFS_EQ_LIMIT: n.rdata = s.eqlim;
				`OFS_DETECT_OVR: n.rdata = s.detovr;
				`OFS_OUTPUT_SEL: n.rdata = s.osel;
				`OFS_RATE_SUBRATE: n.rdata = s.rate;
				`OFS_ADAPT_MODE: n.rdata = s.adapt;
				`OFS_SEARCH_CFG: n.rdata = s.search;
				`OFS_LOW_RATE_BOOST: n.rdata = s.lowb;
				`OFS_RESEARCH_DIS: n.rdata = s.rdis;
				`OFS_SECONDARY_BOOST: n.rdata = s.secb;
				default: n.rdata = 8'h00;
			endcase
		end

		// signal detect: 10 forces on, 01 forces off, else automatic
		case (s.detovr[7:6])
			2'b10: sd_eff = 1'b1; // RL19
			2'b01: sd_eff = 1'b0;
			default: sd_eff = sig_detect; // RL19
		endcase
		hold_boost = (s.adapt[`ADAPT_HI:`ADAPT_LO] == 2'b00) && (s.written == 3'b111); // RL7

		// lock and adaptation sequence
		case (s.st)
			st_off: begin
				if (sd_eff) begin
					if (s.search[`SEARCH_HI:`SEARCH_LO] == 2'b11 && !s.ovr[`BIT_CAP_OVR]) begin
						n.st = st_search; // RL8
						n.cap = search_base(s.rate); // RL9
						n.tmr = 16'h0000;
					end else begin
						go_try = 1'b1;
					end
				end
			end
			st_search: begin
				// one cap step per reference tick until the frequency comparator agrees or the search span ends
				if (ref_tick) begin
					if (freq_ok || s.cap == search_base(s.rate) + 5'(`SEARCH_SPAN - 1)) begin // RL9
						go_try = 1'b1;
					end else begin
						n.cap = s.cap + 5'h01; // RL8
					end
				end
			end
			st_try: begin
				n.tmr = s.tmr + 16'h0001;
				if ((s.div == `DIV_BY4 || s.div == `DIV_BY8) && !hold_boost) begin
					n.boost = s.lowb; // RL6
				end
				if (lock_det) begin
					n.st = st_adapt;
				end else if (s.tmr == 16'(`LOCK_TRY_CYC - 1)) begin
					n.tmr = 16'h0000;
					if (s.ovr[`BIT_CAP_OVR]) begin
						n.alt = ~s.alt; // RL11
						n.cap = s.alt ? s.cap1[4:0] : s.cap2[4:0];
						n.div = s.alt ? `DIV_BY8 : `DIV_BY1;
					end else begin
						n.div = (s.div == `DIV_BY1) ? max_div(s.rate) : s.div - 3'h1; // RL5
					end
				end
			end
			st_adapt: begin
				if (!lock_det) begin
					go_try = 1'b1; // RL3
				end else if (s.adapt[`ADAPT_HI:`ADAPT_LO] == 2'b00) begin
					n.st = st_locked; // RL4
				end else begin
					if (adapt_valid) begin
						n.boost = adapt_boost; // RL3
					end
					if (adapt_done) begin
						n.st = st_locked;
					end
				end
			end
			st_locked: begin
				if (!lock_det) begin
					if (s.rdis[`BIT_RESEARCH_DIS]) begin
						go_try = 1'b1; // RL17
					end else begin
						n.st = st_research;
						n.tmr = 16'h0000;
					end
				end
			end
			st_research: begin
				n.tmr = s.tmr + 16'h0001;
				if (s.tmr == 16'(`RESEARCH_CYC - 1)) begin
					go_try = 1'b1; // RL3
				end
			end
			default: n.st = st_off;
		endcase
		if (go_try) begin
			n.st = st_try;
			n.tmr = 16'h0000;
			n.alt = 1'b0;
			if (s.ovr[`BIT_CAP_OVR]) begin
				n.cap = s.cap1[4:0]; // RL10
				n.div = `DIV_BY8; // RL11
			end else begin
				n.div = (s.search[`REFMODE_HI:`REFMODE_LO] != 3'h0) ? max_div(s.rate) : `DIV_BY1; // RL5
			end
		end
		if (!sd_eff) begin
			n.st = st_off; // RL18
			n.tmr = 16'h0000;
		end

		// output selection
		if (!sd_eff || s.st == st_research) begin
			sel_raw = `MUX_MUTE; // RL18
		end else if (s.ovr[`BIT_MUX_OVR]) begin
			sel_raw = s.osel[`SEL_HI:`SEL_LO]; // RL16
		end else if (s.st == st_locked) begin
			sel_raw = `MUX_RETIMED; // RL12
		end else begin
			sel_raw = s.osel[`SEL_HI:`SEL_LO]; // RL15
		end
		if (sel_raw == `MUX_INVALID) begin
			sel_raw = `MUX_MUTE; // RL22
		end
		if (sel_raw == `MUX_QCLK && !(s.ovr[`BIT_QCLK_EN_A] && s.osel[`BIT_QCLK_EN_B])) begin
			sel_raw = `MUX_MUTE; // RL14
		end
		n.sel = sel_raw;
		n.pwr = sd_eff; // RL18
		n.vsync = (s.st == st_locked); // RL20

		case (s.sel)
			`MUX_OSC10: src_word = {16{s.osc}}; // RL21
			`MUX_PRBS: src_word = prbs_data; // RL13
			`MUX_QCLK: src_word = qclk_data;
			`MUX_ICLK: src_word = iclk_data;
			`MUX_RETIMED: src_word = retimed_data;
			`MUX_RAW: src_word = raw_data;
			default: src_word = 16'h0000; // RL13
		endcase

		// two-entry output buffer
		push = in_valid && s.in_rdy;
		pop = (s.cnt != 2'h0) && out_ready;
		if (pop) begin
			n.buf0 = s.buf1;
			n.cnt = s.cnt - 2'h1;
		end
		if (push) begin
			if (n.cnt == 2'h0) begin
				n.buf0 = src_word;
			end else begin
				n.buf1 = src_word;
			end
			n.cnt = n.cnt + 2'h1;
		end
		n.in_rdy = (n.cnt != 2'h2);
		n.ovalid = (n.cnt != 2'h0);
	end

	// ==================================================
	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.osel <= `RST_OUTPUT_SEL;
			s.search <= `RST_SEARCH_CFG;
			s.adapt <= `RST_ADAPT_MODE;
			s.st <= st_off;
			s.sel <= `MUX_MUTE;
			s.in_rdy <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign reg_rdata = s.rdata;
	assign reg_rvalid = s.rvalid;
	assign in_ready = s.in_rdy;
	assign out_valid = s.ovalid;
	assign out_data = s.buf0;
	assign boost_out = s.boost;
	assign eq_limit_out = s.eqlim[`BIT_EQ_LIMIT];
	assign cap_dac_out = s.cap;
	assign div_code_out = s.div;
	assign chan_power_en = s.pwr;
	assign mux_sel = s.sel;
	assign vco_sync = s.vsync;

	// ==================================================
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	power_down_a: assert property (!sd_eff |=> !chan_power_en && mux_sel == `MUX_MUTE) // RL18
		else $error("channel not powered down without signal");
	force_on_a: assert property (s.detovr[7:6] == 2'b10 |=> chan_power_en) // RL19
		else $error("forced detect did not enable channel");
	locked_data_a: assert property (sd_eff && s.st == st_locked && !s.ovr[`BIT_MUX_OVR]
		|=> mux_sel == `MUX_RETIMED) // RL12
		else $error("locked channel not sending retimed data");
	mux_override_a: assert property (sd_eff && s.ovr[`BIT_MUX_OVR] && s.st != st_research
		&& s.osel[`SEL_HI:`SEL_LO] inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5}
		|=> mux_sel == $past(s.osel[`SEL_HI:`SEL_LO])) // RL16
		else $error("override select not followed");
	invalid_mute_a: assert property (sd_eff && s.osel[`SEL_HI:`SEL_LO] == `MUX_INVALID
		&& (s.ovr[`BIT_MUX_OVR] || s.st != st_locked) |=> mux_sel == `MUX_MUTE) // RL22
		else $error("invalid select not muted");
	low_rate_a: assert property (s.st == st_try && s.div inside {`DIV_BY4, `DIV_BY8} && !hold_boost && sd_eff
		|=> boost_out == $past(s.lowb)) // RL6
		else $error("low-rate boost not applied");
	adapt_hold_a: assert property (s.adapt[6:5] == 2'b00 && !reg_wr && s.st inside {st_adapt, st_locked}
		|=> boost_out == $past(boost_out)) // RL4
		else $error("boost changed with adaptation off");
	relock_seq_a: assert property (sd_eff && s.st == st_locked && !lock_det && s.rdis[`BIT_RESEARCH_DIS]
		|=> s.st == st_try ##1 s.st inside {st_try, st_adapt, st_off}) // RL3
		else $error("lock loss did not restart sequence");
	cap_override_a: assert property (go_try && sd_eff && s.ovr[`BIT_CAP_OVR]
		|=> cap_dac_out == $past(s.cap1[4:0]) && div_code_out == `DIV_BY8) // RL11
		else $error("override try not at first value and ratio 8");
	limit_bit_a: assert property (reg_wr && reg_addr == `OFS_EQ_LIMIT |=> eq_limit_out == $past(reg_wdata[2])) // RL2
		else $error("limiting bit not applied");

	locked_c: cover property (s.st == st_adapt ##1 s.st == st_locked);
	search_c: cover property (s.st == st_search ##[1:200] s.st == st_try);
	research_c: cover property (s.st == st_research ##[1:100] s.st == st_try);
	backpressure_c: cover property (s.cnt == 2'h2 && !out_ready && in_valid);
endmodule : retimer_channel_override_ctrl

// File: tb/retimer_channel_override_ctrl_tb_top.sv
// self-checking testbench of the channel override block
`timescale 1ns/10ps
`include "retimer_params.svh"
module retimer_channel_override_ctrl_tb_top;
	import retimer_pkg::*;
	logic clk, rst, reg_wr, reg_rd, reg_rvalid, sig_detect, lock_det, freq_ok, adapt_valid, adapt_done;
	logic in_valid, in_ready, out_valid, out_ready, eq_limit_out, chan_power_en, vco_sync;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, adapt_boost, boost_out, d;
	logic [4:0] cap_dac_out;
	logic [2:0] div_code_out;
	word_t retimed_data, raw_data, prbs_data, iclk_data, qclk_data, out_data, w0, w1;
	mux_sel_t mux_sel, e;
	integer seed, n_errors, compares, i, j;
	logic [7:0] offs [13] = '{8'h03, 8'h08, 8'h09, 8'h0b, 8'h13, 8'h14, 8'h1e, 8'h2f, 8'h31, 8'h36, 8'h3a, 8'h3f, 8'h40};
	logic [7:0] rstv [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'he0, 8'h00, 8'h20, 8'h31, 8'h00, 8'h00, 8'h00};

	retimer_channel_override_ctrl i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sig_detect(sig_detect),
		.lock_det(lock_det), .freq_ok(freq_ok), .adapt_valid(adapt_valid), .adapt_boost(adapt_boost),
		.adapt_done(adapt_done), .in_valid(in_valid), .in_ready(in_ready), .retimed_data(retimed_data),
		.raw_data(raw_data), .prbs_data(prbs_data), .iclk_data(iclk_data), .qclk_data(qclk_data),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .boost_out(boost_out),
		.eq_limit_out(eq_limit_out), .cap_dac_out(cap_dac_out), .div_code_out(div_code_out),
		.chan_power_en(chan_power_en), .mux_sel(mux_sel), .vco_sync(vco_sync));

	// ==================================================
	// helpers
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		step(1);
		reg_wr = 1'b0;
		step(1);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		reg_addr = a;
		reg_rd = 1'b1;
		step(1);
		reg_rd = 1'b0;
		check(reg_rvalid, 1'b1, "read strobe");
		v = reg_rdata;
		step(1);
	endtask : rd

	function automatic mux_sel_t exp_sel(input logic [2:0] code, input logic q_en);
		if (code == `MUX_INVALID || (code == `MUX_QCLK && !q_en))
			return `MUX_MUTE;
		return code;
	endfunction : exp_sel

	function automatic word_t exp_word(input mux_sel_t s);
		case (s)
			`MUX_RAW: return raw_data;
			`MUX_RETIMED: return retimed_data;
			`MUX_ICLK: return iclk_data;
			`MUX_QCLK: return qclk_data;
			`MUX_PRBS: return prbs_data;
			default: return 16'h0000;
		endcase
	endfunction : exp_word

	task automatic close_out;
		$display("checks %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	initial begin
		#1000000;
		n_errors++;
		close_out;
	end

	// ==================================================
	// tests
	initial begin
		seed = 32'hb9bb_ee36;
		n_errors = 0;
		compares = 0;
		{rst, reg_wr, reg_rd, sig_detect, lock_det, freq_ok, adapt_valid, adapt_done, in_valid} = 9'h1ff;
		{reg_wr, reg_rd, sig_detect, lock_det, freq_ok, adapt_valid, adapt_done, in_valid} = 8'h00;
		{reg_addr, reg_wdata, adapt_boost} = 24'h00_0000;
		{retimed_data, raw_data, prbs_data, iclk_data, qclk_data} = 80'h0;
		out_ready = 1'b1;
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		step(1);
		check({mux_sel, chan_power_en, in_ready, out_valid}, 6'b111_010, "reset outputs");
		for (i = 0; i < 13; i++) begin
			rd(offs[i], d);
			check(d, rstv[i], "reset value");
		end
		rd(8'h55, d);
		check(d, 8'h00, "unmapped read");
		for (i = 1; i < 13; i++) begin
			if (offs[i] != 8'h14) begin
				w0 = 16'($random(seed));
				wr(offs[i], w0[7:0]);
				rd(offs[i], d);
				check(d, w0[7:0], "readback");
			end
		end
		for (i = 0; i < 13; i++)
			wr(offs[i], rstv[i]);
		$display("test registers done");

		w0 = 16'($random(seed));
		wr(8'h03, w0[7:0]);
		check(boost_out, w0[7:0], "boost applied");
		rd(8'h03, d);
		check(d, w0[7:0], "boost readback");
		wr(8'h13, 8'h04);
		check(eq_limit_out, 1'b1, "limit on");
		wr(8'h13, 8'hfb);
		check(eq_limit_out, 1'b0, "limit off");
		check(chan_power_en, 1'b0, "no signal off");
		wr(8'h14, 8'h80);
		step(2);
		check(chan_power_en, 1'b1, "forced on");
		wr(8'h14, 8'h00);
		step(2);
		check(chan_power_en, 1'b0, "auto again");
		$display("test boost and detect done");

		sig_detect = 1'b1;
		wr(8'h3f, 8'h80);
		wr(8'h09, 8'h20);
		for (i = 0; i < 8; i++) begin
			wr(8'h1e, {i[2:0], 5'h00});
			step(3);
			e = exp_sel(i[2:0], 1'b0);
			check(mux_sel, e, "override select");
			{retimed_data, raw_data, prbs_data, iclk_data, qclk_data} = {$random(seed), $random(seed), 16'($random(seed))};
			in_valid = 1'b1;
			step(1);
			in_valid = 1'b0;
			if (e != `MUX_OSC10)
				check(out_data, exp_word(e), "output word");
			else
				check(out_data == 16'h0000 || out_data == 16'hffff, 1'b1, "oscillator word");
			step(1);
		end
		wr(8'h09, 8'h30);
		wr(8'h1e, 8'h61);
		step(3);
		check(mux_sel, `MUX_QCLK, "q clock");
		wr(8'h1e, 8'h00);
		step(3);
		out_ready = 1'b0;
		in_valid = 1'b1;
		w0 = 16'($random(seed));
		raw_data = w0;
		step(1);
		w1 = 16'($random(seed));
		raw_data = w1;
		step(1);
		raw_data = ~w1;
		step(1);
		in_valid = 1'b0;
		check(in_ready, 1'b0, "buffer full");
		out_ready = 1'b1;
		check(out_data, w0, "first word");
		step(1);
		check(out_data, w1, "second word");
		step(1);
		check(out_valid, 1'b0, "buffer empty");
		$display("test mux and buffer done");

		wr(8'h09, 8'h00);
		wr(8'h08, 8'h0a);
		wr(8'h0b, 8'h15);
		wr(8'h09, 8'h80);
		for (i = 0; i < 2; i++) begin
			for (j = 0; j < 600 && div_code_out !== `DIV_BY8; j++)
				step(1);
			check(cap_dac_out, 5'h0a, "first cap at div8");
			for (j = 0; j < 600 && div_code_out !== `DIV_BY1; j++)
				step(1);
			check(cap_dac_out, 5'h15, "second cap at div1");
		end
		wr(8'h09, 8'h00);
		wr(8'h2f, 8'h30);
		wr(8'h3a, 8'h33);
		for (j = 0; j < 2000 && div_code_out !== `DIV_BY8; j++)
			step(1);
		step(2);
		check(boost_out, 8'h33, "low rate boost");
		sig_detect = 1'b0;
		step(2);
		sig_detect = 1'b1;
		step(1);
		check(cap_dac_out, 5'h06, "search base");
		step(40);
		check(cap_dac_out, 5'h0d, "search end");
		wr(8'h2f, 8'h00);
		$display("test search done");

		wr(8'h31, 8'h00);
		wr(8'h03, 8'h5a);
		step(5);
		check(mux_sel, `MUX_RAW, "unlocked select");
		{lock_det, freq_ok, adapt_done} = 3'b111;
		for (j = 0; j < 3000 && vco_sync !== 1'b1; j++) begin
			adapt_valid = 1'b1;
			adapt_boost = 8'($random(seed));
			step(1);
		end
		adapt_valid = 1'b0;
		check({vco_sync, mux_sel}, {1'b1, `MUX_RETIMED}, "locked");
		check(boost_out, 8'h5a, "adapt mode zero");
		lock_det = 1'b0;
		for (j = 0; j < 20 && vco_sync !== 1'b0; j++)
			step(1);
		step(2);
		check({vco_sync, mux_sel}, {1'b0, `MUX_RAW}, "lock lost");
		lock_det = 1'b1;
		for (j = 0; j < 3000 && vco_sync !== 1'b1; j++)
			step(1);
		check(vco_sync, 1'b1, "relocked");
		wr(8'h3f, 8'h00);
		lock_det = 1'b0;
		step(3);
		check(mux_sel, `MUX_MUTE, "re-search mutes");
		step(60);
		check(mux_sel, `MUX_RAW, "re-search over");
		sig_detect = 1'b0;
		step(2);
		check({chan_power_en, mux_sel}, {1'b0, `MUX_MUTE}, "signal gone");
		$display("test lock done");
		close_out;
	end
endmodule : retimer_channel_override_ctrl_tb_top
